/* File: rtl/dpa_pkg.sv */
// Constants, types and field layout of the phase accumulator core.
// Function
// - Phase accumulator wraps modulo 2^48, stepping by the tuning word.
// - Tuning word input is 48 bits wide.
// - Every sample clock the tuning word is added to the registered total; the core skips the add while its sample FIFO is full.
// - Overflow wraps and keeps the remainder, giving rate step/2^48 times fs.
// - A programmable 14-bit phase offset shifts the output phase.
// - One offset unit equals one part in 2^14 of a full cycle.
// - A 10-bit unsigned full-scale code scales DAC peak current.
// - Full-scale current is Iref times (72 + 192*code/1024).
// - Reset full-scale code gives 20 mA with the recommended resistor.
// - Core and DAC share the system clock as sample clock.
// - One new amplitude sample goes to the DAC per sample clock; the core sends none in a clock where the DAC holds dac_ready_i low.
// - Built-in frequency profiles run without programming the tuning word.
// - Buffered values become active only on a rising update strobe.
// - Reset input holds the core in reset; a 10 us pulse follows power-up.
// - Power-down input makes the core inactive.
`default_nettype none
package dpa_pkg;
    localparam int TUNE_W = 48;
    localparam int PHASE_W = 14;
    localparam int SCALE_W = 10;
    localparam int SAMPLE_W = 14;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int PIPE_DEPTH = 3;
    // Register offsets
    localparam logic [7:0] OFS_TUNE_LO = 8'h00;
    localparam logic [7:0] OFS_TUNE_HI = 8'h04;
    localparam logic [7:0] OFS_PHASE = 8'h08;
    localparam logic [7:0] OFS_SCALE = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_ACT_TUNE_LO = 8'h14;
    localparam logic [7:0] OFS_ACT_TUNE_HI = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    // Control fields
    localparam int CTRL_PROF_EN_BIT = 0;
    localparam int CTRL_PROF_SEL_LSB = 1;
    localparam int CTRL_W = 3;
    // Status fields
    localparam int ST_RUN_BIT = 0;
    localparam int ST_PDOWN_BIT = 1;
    localparam int ST_FULL_BIT = 2;
    localparam int ST_EMPTY_BIT = 3;
    localparam int ST_POR_BIT = 4;
    // Reset values; 505 gives 120 uA * (72 + 192*505/1024) = 20 mA
    localparam logic [47:0] RST_TUNE = 48'h0000_0000_0000;
    localparam logic [13:0] RST_PHASE = 14'h0000;
    localparam logic [9:0] RST_SCALE = 10'h1F9;
    localparam logic [2:0] RST_CTRL = 3'h0;
    // Built-in profiles (fs/8, fs/16, fs/32, fs/64)
    localparam logic [47:0] PROF_TUNE_0 = 48'h2000_0000_0000;
    localparam logic [47:0] PROF_TUNE_1 = 48'h1000_0000_0000;
    localparam logic [47:0] PROF_TUNE_2 = 48'h0800_0000_0000;
    localparam logic [47:0] PROF_TUNE_3 = 48'h0400_0000_0000;
    // Power-up reset timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int POR_TIME_NS = 10000;
    localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [13:0] MIDSCALE = 14'h2000;
    typedef enum logic [1:0] {
        DPA_ST_POR,
        DPA_ST_RUN,
        DPA_ST_SLEEP
    } dpa_state_t;
endpackage
`default_nettype wire

/* File: rtl/dpa_core.sv */
// Phase accumulator core with sample FIFO and register port.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Sample FIFO between the sine stage and the DAC
module dpa_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic full_o,
    output logic empty_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
    logic push, pop;

    // Flags and handshakes
    assign full_o = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty_o = (wr_ptr_ff == rd_ptr_ff);
    assign in_ready_o = !full_o;
    assign out_valid_o = !empty_o;
    assign push = in_valid_i && !full_o;
    assign pop = out_ready_i && !empty_o;
    assign out_data_o = mem_ff[rd_ptr_ff[AW-1:0]];

    // Pointer next values
    always_comb begin
        nxt_wr_ptr = wr_ptr_ff + (push ? (AW+1)'(1) : (AW+1)'(0));
        nxt_rd_ptr = rd_ptr_ff + (pop ? (AW+1)'(1) : (AW+1)'(0));
    end

    // Pointer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    // Storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Accumulator, offset, sine stage and control registers
module dpa_core
    import dpa_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic power_down_input_i,
    input wire logic io_update_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic [SAMPLE_W-1:0] dac_sample_o,
    output logic dac_valid_o,
    input wire logic dac_ready_i,
    output logic [SCALE_W-1:0] dac_fullscale_code_o,
    output logic dac_enable_o
);
    // Offset-binary sine approximation, parabola per half cycle
    function automatic logic [SAMPLE_W-1:0] sine_of(input logic [PHASE_W-1:0] ph);
        logic [12:0] half;
        logic [13:0] rest;
        logic [26:0] prod;
        logic [12:0] mag;
        half = ph[12:0];
        rest = 14'h2000 - {1'b0, half};
        prod = 27'({14'h0000, half} * {13'h0000, rest});
        mag = prod[24] ? 13'h1FFF : prod[23:11];
        sine_of = ph[13] ? (MIDSCALE - {1'b0, mag}) : (MIDSCALE + {1'b0, mag});
    endfunction

    // Built-in profile table
    function automatic logic [TUNE_W-1:0] profile_tune(input logic [1:0] sel);
        case (sel)
            2'h0: profile_tune = PROF_TUNE_0;
            2'h1: profile_tune = PROF_TUNE_1;
            2'h2: profile_tune = PROF_TUNE_2;
            default: profile_tune = PROF_TUNE_3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Power-up reset pulse and run state
    logic [10:0] por_cnt_ff = '0;
    logic [10:0] nxt_por_cnt;
    dpa_state_t state_ff, nxt_state;
    logic core_rst;
    logic adv;
    logic fifo_in_ready, fifo_full, fifo_empty;

    assign core_rst = rst_i || (por_cnt_ff != 11'(POR_CYCLES));

    // Power-up counter runs once, is restarted by nothing
    always_comb begin
        nxt_por_cnt = por_cnt_ff;
        if (por_cnt_ff != 11'(POR_CYCLES)) begin
            nxt_por_cnt = por_cnt_ff + 11'h001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        por_cnt_ff <= nxt_por_cnt;
    end

    // Run / sleep state
    always_comb begin
        case (state_ff)
            DPA_ST_POR: nxt_state = DPA_ST_RUN;
            DPA_ST_RUN: nxt_state = power_down_input_i ? DPA_ST_SLEEP : DPA_ST_RUN;
            DPA_ST_SLEEP: nxt_state = power_down_input_i ? DPA_ST_SLEEP : DPA_ST_RUN;
            default: nxt_state = DPA_ST_POR;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            state_ff <= DPA_ST_POR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Pipeline advances each clock in the run state unless power-down is high or the FIFO is full
    assign adv = (state_ff == DPA_ST_RUN) && !power_down_input_i && fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Buffered and active control registers
    logic [TUNE_W-1:0] buf_tune_ff, nxt_buf_tune, act_tune_ff, nxt_act_tune;
    logic [PHASE_W-1:0] buf_phase_ff, nxt_buf_phase, act_phase_ff, nxt_act_phase;
    logic [SCALE_W-1:0] buf_scale_ff, nxt_buf_scale, act_scale_ff, nxt_act_scale;
    logic [CTRL_W-1:0] buf_ctrl_ff, nxt_buf_ctrl, act_ctrl_ff, nxt_act_ctrl;
    logic upd_prev_ff, nxt_upd_prev;
    logic upd_rise;

    assign upd_rise = io_update_i && !upd_prev_ff;

    always_comb begin
        nxt_buf_tune = buf_tune_ff;
        nxt_buf_phase = buf_phase_ff;
        nxt_buf_scale = buf_scale_ff;
        nxt_buf_ctrl = buf_ctrl_ff;
        nxt_upd_prev = io_update_i;
        if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_TUNE_LO: nxt_buf_tune[31:0] = reg_wdata_i;
                OFS_TUNE_HI: nxt_buf_tune[47:32] = reg_wdata_i[15:0];
                OFS_PHASE: nxt_buf_phase = reg_wdata_i[PHASE_W-1:0];
                OFS_SCALE: nxt_buf_scale = reg_wdata_i[SCALE_W-1:0];
                OFS_CTRL: nxt_buf_ctrl = reg_wdata_i[CTRL_W-1:0];
                default: nxt_buf_ctrl = buf_ctrl_ff;
            endcase
        end
        // Copy takes the values buffered before this edge's write
        nxt_act_tune = upd_rise ? buf_tune_ff : act_tune_ff;
        nxt_act_phase = upd_rise ? buf_phase_ff : act_phase_ff;
        nxt_act_scale = upd_rise ? buf_scale_ff : act_scale_ff;
        nxt_act_ctrl = upd_rise ? buf_ctrl_ff : act_ctrl_ff;
    end

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            buf_tune_ff <= RST_TUNE;
            buf_phase_ff <= RST_PHASE;
            buf_scale_ff <= RST_SCALE;
            buf_ctrl_ff <= RST_CTRL;
            act_tune_ff <= RST_TUNE;
            act_phase_ff <= RST_PHASE;
            act_scale_ff <= RST_SCALE;
            act_ctrl_ff <= RST_CTRL;
            upd_prev_ff <= 1'b1;
        end else begin
            buf_tune_ff <= nxt_buf_tune;
            buf_phase_ff <= nxt_buf_phase;
            buf_scale_ff <= nxt_buf_scale;
            buf_ctrl_ff <= nxt_buf_ctrl;
            act_tune_ff <= nxt_act_tune;
            act_phase_ff <= nxt_act_phase;
            act_scale_ff <= nxt_act_scale;
            act_ctrl_ff <= nxt_act_ctrl;
            upd_prev_ff <= nxt_upd_prev;
        end
    end

    // Analog current is Iref*(72+192*code/1024); the core only supplies the code
    assign dac_fullscale_code_o = act_scale_ff;
    assign dac_enable_o = (state_ff == DPA_ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator, phase offset and sine pipeline
    logic [TUNE_W-1:0] step;
    logic [TUNE_W-1:0] acc_ff, nxt_acc;
    logic [PHASE_W-1:0] phase_ff, nxt_phase;
    logic [SAMPLE_W-1:0] sample_ff, nxt_sample;
    logic [PIPE_DEPTH-1:0] vld_ff, nxt_vld;

    assign step = act_ctrl_ff[CTRL_PROF_EN_BIT]
        ? profile_tune(act_ctrl_ff[CTRL_PROF_SEL_LSB +: 2]) : act_tune_ff;

    always_comb begin
        nxt_acc = acc_ff;
        nxt_phase = phase_ff;
        nxt_sample = sample_ff;
        nxt_vld = vld_ff;
        if (adv) begin
            nxt_acc = acc_ff + step;
            nxt_phase = acc_ff[TUNE_W-1 -: PHASE_W] + act_phase_ff;
            nxt_sample = sine_of(phase_ff);
            nxt_vld = {vld_ff[PIPE_DEPTH-2:0], 1'b1};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            acc_ff <= '0;
            phase_ff <= '0;
            sample_ff <= MIDSCALE;
            vld_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
            phase_ff <= nxt_phase;
            sample_ff <= nxt_sample;
            vld_ff <= nxt_vld;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample FIFO toward the DAC
    dpa_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(core_clk_i),
        .rst_i(core_rst),
        .in_data_i(sample_ff),
        .in_valid_i(vld_ff[PIPE_DEPTH-1] && adv),
        .in_ready_o(fifo_in_ready),
        .out_data_o(dac_sample_o),
        .out_valid_o(dac_valid_o),
        .out_ready_i(dac_ready_i),
        .full_o(fifo_full),
        .empty_o(fifo_empty)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register read port, data one cycle after the strobe
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;

    always_comb begin
        nxt_rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_TUNE_LO: nxt_rdata = buf_tune_ff[31:0];
                OFS_TUNE_HI: nxt_rdata = {16'h0000, buf_tune_ff[47:32]};
                OFS_PHASE: nxt_rdata = {18'h00000, buf_phase_ff};
                OFS_SCALE: nxt_rdata = {22'h000000, buf_scale_ff};
                OFS_CTRL: nxt_rdata = {29'h00000000, buf_ctrl_ff};
                OFS_ACT_TUNE_LO: nxt_rdata = step[31:0];
                OFS_ACT_TUNE_HI: nxt_rdata = {16'h0000, step[47:32]};
                OFS_STATUS: begin
                    nxt_rdata[ST_RUN_BIT] = (state_ff == DPA_ST_RUN);
                    nxt_rdata[ST_PDOWN_BIT] = (state_ff == DPA_ST_SLEEP);
                    nxt_rdata[ST_FULL_BIT] = fifo_full;
                    nxt_rdata[ST_EMPTY_BIT] = fifo_empty;
                    nxt_rdata[ST_POR_BIT] = core_rst;
                end
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;
endmodule

`default_nettype wire

/* File: sim/dpa_core_chk.sv */
// Port-level assertions of the phase accumulator core.
`timescale 1ns/10ps
`default_nettype none
module dpa_core_chk
    import dpa_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic power_down_input_i,
    input wire logic io_update_i,
    input wire logic reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [SAMPLE_W-1:0] dac_sample_o,
    input wire logic dac_valid_o,
    input wire logic dac_ready_i,
    input wire logic [SCALE_W-1:0] dac_fullscale_code_o,
    input wire logic dac_enable_o
);
    logic [11:0] up_cnt_ff = 12'h000;
    logic [11:0] nxt_up_cnt;
    logic por_done;
    // Saturating count since time zero, masks the power-up reset
    always_comb begin
        nxt_up_cnt = (up_cnt_ff == 12'hFFF) ? up_cnt_ff : up_cnt_ff + 12'h001;
    end
    always_ff @(posedge core_clk_i) begin
        up_cnt_ff <= nxt_up_cnt;
    end
    assign por_done = up_cnt_ff > 12'(POR_CYCLES + 4);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Register port and update strobe
    AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside read cycle");
    AST_SCALE_CHG: assert property ($changed(dac_fullscale_code_o) |-> $past(rst_i)
        || ($past(io_update_i) && !$past(io_update_i, 2)) || ($past(io_update_i, 2) && !$past(io_update_i, 3)))
        else $error("scale code moved without update rise");
    AST_RST_LOAD: assert property ($fell(rst_i) |-> dac_fullscale_code_o == RST_SCALE && !dac_valid_o)
        else $error("reset defaults not loaded");
    // Power state and sample stream
    AST_PD_OFF: assert property (power_down_input_i [*3] |-> !dac_enable_o)
        else $error("enabled while powered down");
    AST_PD_HOLD: assert property ((power_down_input_i [*6]) ##0 !dac_valid_o |=> !dac_valid_o)
        else $error("sample produced while powered down");
    AST_WAKE: assert property ((por_done && !power_down_input_i && !rst_i) [*3] |-> dac_enable_o)
        else $error("not running after release");
    AST_HOLD: assert property (dac_valid_o && !dac_ready_i |=> dac_valid_o && $stable(dac_sample_o))
        else $error("sample dropped while stalled");
    AST_FLOW: assert property (dac_enable_o [*8] |-> dac_valid_o)
        else $error("no sample while running");
endmodule
bind dpa_core dpa_core_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .power_down_input_i(power_down_input_i),
    .io_update_i(io_update_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .dac_sample_o(dac_sample_o),
    .dac_valid_o(dac_valid_o), .dac_ready_i(dac_ready_i), .dac_fullscale_code_o(dac_fullscale_code_o),
    .dac_enable_o(dac_enable_o));
`default_nettype wire

/* File: sim/dpa_dac_model.sv */
// Behavioural DAC sink that takes and records samples.
`timescale 1ns/10ps
`default_nettype none
module dpa_dac_model
    import dpa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic valid_i,
    output logic ready_o
);
    logic [SAMPLE_W-1:0] got[$];
    // Mode 0 prompt, 1 random stalls, 2 stalled
    always @(posedge clk_i) begin
        if (rst_i) begin
            got.delete();
        end else if (valid_i && ready_o) begin
            got.push_back(sample_i);
        end
        ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && $urandom_range(1) == 1);
    end
endmodule
`default_nettype wire

/* File: sim/dpa_core_tb_top.sv */
// Self-checking bench of the phase accumulator core.
`timescale 1ns/10ps
`default_nettype none
module dpa_core_tb_top
    import dpa_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pd = 1'b0;
    logic upd = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata, d;
    logic [SAMPLE_W-1:0] smp;
    logic vld, rdy, en;
    logic [SCALE_W-1:0] dac_code, fs;
    logic [1:0] mode = 2'h0;
    logic [47:0] tune, acc;
    logic [13:0] off;
    logic [47:0] prof [4] = '{PROF_TUNE_0, PROF_TUNE_1, PROF_TUNE_2, PROF_TUNE_3};
    int fail_count = 0;
    int n_compared = 0;
    int k;
    dpa_core DUT (.core_clk_i(clk), .rst_i(rst), .power_down_input_i(pd), .io_update_i(upd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .dac_sample_o(smp),
        .dac_valid_o(vld), .dac_ready_i(rdy), .dac_fullscale_code_o(dac_code), .dac_enable_o(en));
    dpa_dac_model u_dac (.clk_i(clk), .rst_i(rst), .mode_i(mode), .sample_i(smp), .valid_i(vld), .ready_o(rdy));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
    // Compare, bus cycles and expected sine
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic pulse_upd();
        @(posedge clk);
        upd <= 1'b1;
        @(posedge clk);
        upd <= 1'b0;
    endtask
    function automatic logic [13:0] sine(input logic [13:0] p);
        logic [26:0] m;
        m = (27'(p[12:0]) * (27'h2000 - 27'(p[12:0]))) >> 11;
        if (m > 27'h1FFF) m = 27'h1FFF;
        return p[13] ? 14'h2000 - m[13:0] : 14'h2000 + m[13:0];
    endfunction
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h403B));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (100) @(posedge clk);
        #1 chk(en, 1'b0);
        repeat (POR_CYCLES) @(posedge clk);
        rd_reg(OFS_STATUS);
        chk({d[4], d[1:0]}, 3'b001);
        rd_reg(OFS_SCALE);
        chk(d, RST_SCALE);
        chk(dac_code, RST_SCALE);
        for (int it = 0; it < 3; it++) begin
            tune = 48'({$urandom(), $urandom()}) & 48'h3FFF_FFFF_FFFF;
            if (it == 0) tune = 48'h3FFF_FFFF_FFFF;
            off = 14'($urandom()) | 14'h0001;
            fs = 10'($urandom());
            @(posedge clk);
            rst <= 1'b1;
            mode <= 2'h0;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
            wr_reg(OFS_TUNE_LO, tune[31:0]);
            wr_reg(OFS_TUNE_HI, {16'h0000, tune[47:32]});
            wr_reg(OFS_PHASE, {18'h00000, off});
            wr_reg(OFS_SCALE, {22'h000000, fs});
            rd_reg(OFS_ACT_TUNE_LO);
            chk(d, '0);
            chk(dac_code, RST_SCALE);
            pulse_upd();
            mode <= 2'h1;
            repeat (2) @(posedge clk);
            #1 chk(dac_code, fs);
            rd_reg(OFS_ACT_TUNE_LO);
            chk(d, tune[31:0]);
            rd_reg(OFS_ACT_TUNE_HI);
            chk(d[15:0], tune[47:32]);
            repeat (200) @(posedge clk);
            k = 0;
            while (k < 60 && u_dac.got[k] === 14'h2000) k++;
            acc = '0;
            for (int j = 0; j < 40; j++) begin
                chk(u_dac.got[k + j], sine(acc[47:34] + off));
                acc += tune;
            end
        end
        for (int s = 0; s < 4; s++) begin
            wr_reg(OFS_CTRL, 32'(s * 2 + 1));
            pulse_upd();
            rd_reg(OFS_ACT_TUNE_HI);
            chk(d[15:0], prof[s][47:32]);
            rd_reg(OFS_ACT_TUNE_LO);
            chk(d, prof[s][31:0]);
        end
        @(posedge clk);
        mode <= 2'h2;
        repeat (40) @(posedge clk);
        rd_reg(OFS_STATUS);
        chk({d[2], vld}, 2'b11);
        @(posedge clk);
        pd <= 1'b1;
        mode <= 2'h0;
        repeat (40) @(posedge clk);
        rd_reg(OFS_STATUS);
        chk(d[4:0], 5'h0A);
        chk({en, vld}, 2'b00);
        @(posedge clk);
        pd <= 1'b0;
        repeat (10) @(posedge clk);
        #1 chk(en, 1'b1);
        rd_reg(8'h20);
        chk(d, '0);
        give_verdict();
    end
endmodule
`default_nettype wire
